// ---- hdl/fsp_sequencer.sv ----
// flash row self-programming sequencer with Avalon-MM register port
// assumes the flash array and its write latches sit outside and obey go and erase
//
// Notes on behaviour
// - full setup, unlock, start needed; else nothing
// - control bit 15 launches the operation
// - hardware clears bit 15 at completion
// - operation lasts 2 ms, core stalled throughout
// - operations act on one 32-word row
// - row address is page plus 16-bit offset
// - table address is page plus EA; bit7 configuration
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module fsp_sequencer
#(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // flash array control
  output logic flash_go_out,
  output logic flash_erase_out,
  output logic [23:0] flash_row_addr_out,
  output logic core_stall_out,
  // table access address construction
  input wire logic [15:0] table_ea_in,
  output logic [23:0] table_addr_out,
  output logic table_config_space_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  fsp_timer_if tmr_link (); // launch and busy link to the timer

  logic [15:0] flash_op_control; // control: start, permit, erase, op type
  logic [7:0] row_page_reg; // upper part of the row address
  logic [15:0] row_offset_reg; // in-page effective address
  logic [7:0] table_page_select; // page for table reads and writes
  fsp_pkg::fsp_key_t key_state; // unlock tracker
  fsp_pkg::fsp_key_t next_key_state;
  logic ack; // bus answer cycle
  logic bus_req; // read or write pending
  logic bus_fire; // access completes at this edge
  logic wr_fire; // write completes at this edge
  logic launch; // accepted start request
  logic [15:0] ctl_written; // control value after a write

  // merge a 16-bit write through the two low byte enables
  function automatic logic [15:0] be_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] be);
    be_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // address decode shared by the write and read paths
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, held off entirely while the core stalls

  assign bus_req = avs_read_in | avs_write_in;
  assign bus_fire = bus_req & ack;
  assign wr_fire = avs_write_in & ack;
  assign avs_waitrequest_out = bus_req & ~ack;

  // answer one cycle after the request, never during a flash cycle
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= bus_req & ~ack & ~tmr_link.busy;
    end
  end

  // read data loaded on the edge that raises ack
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
    end
    else if (avs_read_in && !ack && !tmr_link.busy)
    begin
      if (hit(avs_address_in, fsp_pkg::OFS_CONTROL))
        avs_readdata_out <= {16'h0000, flash_op_control};
      else if (hit(avs_address_in, fsp_pkg::OFS_PAGE))
        avs_readdata_out <= {24'h00_0000, row_page_reg};
      else if (hit(avs_address_in, fsp_pkg::OFS_OFFSET))
        avs_readdata_out <= {16'h0000, row_offset_reg};
      else if (hit(avs_address_in, fsp_pkg::OFS_TBLPAGE))
        avs_readdata_out <= {24'h00_0000, table_page_select};
      else
        avs_readdata_out <= 32'h0000_0000; // key register and holes read zero
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // unlock tracker: 55 then AA as back-to-back key writes opens it

  always_comb
  begin
    next_key_state = key_state;
    if (wr_fire)
    begin
      if (hit(avs_address_in, fsp_pkg::OFS_KEY) && avs_byteenable_in[0]
          && avs_writedata_in[7:0] == fsp_pkg::KEY_FIRST)
        next_key_state = fsp_pkg::FSP_KEY_HALF;
      else if (hit(avs_address_in, fsp_pkg::OFS_KEY) && avs_byteenable_in[0]
               && avs_writedata_in[7:0] == fsp_pkg::KEY_SECOND && key_state == fsp_pkg::FSP_KEY_HALF)
        next_key_state = fsp_pkg::FSP_KEY_OPEN;
      else
        next_key_state = fsp_pkg::FSP_KEY_IDLE;
    end
  end

  // state register; a stray code falls back to locked
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      key_state <= fsp_pkg::FSP_KEY_IDLE;
    end
    else
    begin
      unique case (next_key_state)
        fsp_pkg::FSP_KEY_IDLE: key_state <= fsp_pkg::FSP_KEY_IDLE;
        fsp_pkg::FSP_KEY_HALF: key_state <= fsp_pkg::FSP_KEY_HALF;
        fsp_pkg::FSP_KEY_OPEN: key_state <= fsp_pkg::FSP_KEY_OPEN;
        default: key_state <= fsp_pkg::FSP_KEY_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start acceptance

  assign ctl_written = be_merge(flash_op_control, avs_writedata_in[15:0], avs_byteenable_in[1:0]);

  // launch only on an opened lock, with permit and a row op requested
  assign launch = wr_fire && hit(avs_address_in, fsp_pkg::OFS_CONTROL) && avs_byteenable_in[1]
                  && avs_writedata_in[fsp_pkg::CTL_START_BIT]
                  && key_state == fsp_pkg::FSP_KEY_OPEN
                  && ctl_written[fsp_pkg::CTL_PERMIT_BIT]
                  && ctl_written[fsp_pkg::CTL_OP_MSB:fsp_pkg::CTL_OP_LSB] == fsp_pkg::CTL_OP_ROW;

  assign tmr_link.start = launch;

  ////////////////////////////////////////////////////////////////////////////////
  // control register: software fields plus the hardware-owned start bit

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flash_op_control <= fsp_pkg::CTL_RESET;
    end
    else
    begin
      if (wr_fire && hit(avs_address_in, fsp_pkg::OFS_CONTROL))
      begin
        // software fields only; start is never written directly
        flash_op_control <= (ctl_written & fsp_pkg::CTL_SW_MASK)
                            | {launch, 15'h0000};
      end
      else if (tmr_link.done)
      begin
        flash_op_control[fsp_pkg::CTL_START_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address registers

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      row_page_reg <= fsp_pkg::PAGE_RESET;
      row_offset_reg <= fsp_pkg::OFFSET_RESET;
      table_page_select <= fsp_pkg::TBLPAGE_RESET;
    end
    else if (wr_fire)
    begin
      if (hit(avs_address_in, fsp_pkg::OFS_PAGE) && avs_byteenable_in[0])
        row_page_reg <= avs_writedata_in[7:0];
      if (hit(avs_address_in, fsp_pkg::OFS_OFFSET))
        row_offset_reg <= be_merge(row_offset_reg, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
      if (hit(avs_address_in, fsp_pkg::OFS_TBLPAGE) && avs_byteenable_in[0])
        table_page_select <= avs_writedata_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flash array outputs, captured at launch

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      flash_go_out <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_row_addr_out <= 24'h00_0000;
    end
    else
    begin
      flash_go_out <= launch;
      if (launch)
      begin
        flash_erase_out <= ctl_written[fsp_pkg::CTL_ERASE_BIT];
        // page over in-page offset, trimmed to the row boundary
        flash_row_addr_out <= {row_page_reg, row_offset_reg[15:fsp_pkg::ROW_ALIGN_BITS],
                               {fsp_pkg::ROW_ALIGN_BITS{1'b0}}};
      end
    end
  end

  assign core_stall_out = tmr_link.busy;

  ////////////////////////////////////////////////////////////////////////////////
  // table access address: page above the data effective address

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      table_addr_out <= 24'h00_0000;
      table_config_space_out <= 1'b0;
    end
    else
    begin
      table_addr_out <= {table_page_select, table_ea_in};
      table_config_space_out <= table_page_select[fsp_pkg::TBL_CONFIG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operation timer

  fsp_op_timer #(.OP_CYCLES(OP_CYCLES)) u_timer
  (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .tmr(tmr_link.timer)
  );

endmodule
`default_nettype wire

// ---- hdl/fsp_pkg.sv ----
// constants, register map and types of the flash row self-programming sequencer
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register port
package fsp_pkg;

  // timing: one erase or program cycle lasts nominally 2 ms
  localparam int CLK_FREQ_MHZ = 100;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = OP_TIME_US * CLK_FREQ_MHZ;

  // register byte offsets on the Avalon-MM port
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_KEY = 5'h04;
  localparam logic [4:0] OFS_PAGE = 5'h08;
  localparam logic [4:0] OFS_OFFSET = 5'h0c;
  localparam logic [4:0] OFS_TBLPAGE = 5'h10;

  // control register fields
  localparam int CTL_START_BIT = 15;
  localparam int CTL_PERMIT_BIT = 14;
  localparam int CTL_ERASE_BIT = 6;
  localparam int CTL_OP_MSB = 3;
  localparam int CTL_OP_LSB = 0;
  localparam logic [3:0] CTL_OP_ROW = 4'h1;
  localparam logic [15:0] CTL_SW_MASK = 16'h404f;

  // reset values
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [7:0] TBLPAGE_RESET = 8'h00;

  // unlock key values, in order
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // row geometry: 32 instruction words, two address units each
  localparam int ROW_WORDS = 32;
  localparam int ROW_ALIGN_BITS = 6;

  // table page bit that selects configuration space
  localparam int TBL_CONFIG_BIT = 7;

  // unlock tracker states
  typedef enum logic [1:0]
  {
    FSP_KEY_IDLE = 2'b00,
    FSP_KEY_HALF = 2'b01,
    FSP_KEY_OPEN = 2'b10
  } fsp_key_t;

endpackage

// ---- hdl/fsp_timer_if.sv ----
// carrier between the sequencer and its operation timer
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface fsp_timer_if;
  logic start; // one-cycle launch pulse
  logic busy; // high while the flash cycle runs
  logic done; // one-cycle pulse at the end of the cycle
  modport ctrl (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

// ---- hdl/fsp_op_timer.sv ----
// timer that measures out one flash erase or program cycle
// assumes start only arrives while the timer is idle
`timescale 1ns/100ps
`default_nettype none
module fsp_op_timer
#(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // link to the sequencer
  fsp_timer_if.timer tmr
);

  localparam int CW = $clog2(OP_CYCLES + 1);

  logic [CW-1:0] cnt; // cycles left in the current operation

  ////////////////////////////////////////////////////////////////////////////////
  // busy lasts exactly OP_CYCLES cycles; done marks the last busy cycle so that
  // the start bit clears on the same edge at which the stall ends
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cnt <= '0;
      tmr.busy <= 1'b0;
      tmr.done <= 1'b0;
    end
    else
    begin
      tmr.done <= 1'b0;
      if (!tmr.busy && tmr.start)
      begin
        // launch: load the nominal cycle length less one
        tmr.busy <= 1'b1;
        cnt <= CW'(OP_CYCLES - 1);
        tmr.done <= (OP_CYCLES == 1);
      end
      else if (tmr.busy)
      begin
        if (cnt == '0)
        begin
          // cycle over
          tmr.busy <= 1'b0;
        end
        else
        begin
          cnt <= cnt - 1'b1;
          // flag the final busy cycle
          tmr.done <= (cnt == CW'(1));
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- verif/fsp_seq_asserts.sv ----
// port checker for the flash row sequencer
// assumes it is bound onto fsp_sequencer, one clock domain
`timescale 1ns/100ps
`default_nettype none
module fsp_seq_asserts
#(
  parameter int unsigned OP_CYCLES = fsp_pkg::OP_CYCLES
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // register bus
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  // flash control and table address
  input wire logic flash_go_out,
  input wire logic [23:0] flash_row_addr_out,
  input wire logic core_stall_out,
  input wire logic [15:0] table_ea_in,
  input wire logic [23:0] table_addr_out,
  input wire logic table_config_space_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////
  // counts cycles of the current stall
  logic [31:0] stall_cnt;
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      stall_cnt <= 32'h0000_0000;
    else
      stall_cnt <= core_stall_out ? stall_cnt + 32'h0000_0001 : 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////
  // accepted control write carrying the start bit
  sequence s_start_wr;
    avs_write_in && !avs_waitrequest_out && avs_address_in == fsp_pkg::OFS_CONTROL && avs_writedata_in[15];
  endsequence
  // launch pulse with the core already stalled
  sequence s_launch;
    flash_go_out && core_stall_out;
  endsequence
  property p_go_cause;
    flash_go_out |-> $past(avs_write_in && !avs_waitrequest_out && avs_address_in == fsp_pkg::OFS_CONTROL
      && avs_writedata_in[15]);
  endproperty
  property p_go_stall;
    s_start_wr ##1 flash_go_out |-> s_launch;
  endproperty
  property p_go_pulse;
    flash_go_out |=> !flash_go_out;
  endproperty
  property p_stall_rise;
    $rose(core_stall_out) |-> flash_go_out;
  endproperty
  property p_stall_len;
    $fell(core_stall_out) |-> stall_cnt == OP_CYCLES;
  endproperty
  property p_bus_hold;
    core_stall_out && (avs_read_in || avs_write_in) |-> avs_waitrequest_out;
  endproperty
  property p_row_align;
    flash_go_out |-> flash_row_addr_out[5:0] == 6'h00;
  endproperty
  property p_tbl_ea;
    $past(nrst_in) |-> table_addr_out[15:0] == $past(table_ea_in);
  endproperty
  property p_tbl_cfg;
    table_config_space_out == table_addr_out[23];
  endproperty
  property p_one_wait;
    $rose(avs_read_in || avs_write_in) && !core_stall_out |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("launch without accepted start write");
  a_go_stall: assert property (p_go_stall) else $error("launch without stall");
  a_go_pulse: assert property (p_go_pulse) else $error("launch pulse too long");
  a_stall_rise: assert property (p_stall_rise) else $error("stall without launch");
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  a_bus_hold: assert property (p_bus_hold) else $error("bus answered during stall");
  a_row_align: assert property (p_row_align) else $error("row address not aligned");
  a_tbl_ea: assert property (p_tbl_ea) else $error("table offset wrong");
  a_tbl_cfg: assert property (p_tbl_cfg) else $error("config space flag wrong");
  a_one_wait: assert property (p_one_wait) else $error("idle access wait wrong");
endmodule
bind fsp_sequencer fsp_seq_asserts #(.OP_CYCLES(OP_CYCLES)) fsp_seq_asserts_i (.mclk_in(mclk_in),
  .nrst_in(nrst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
  .flash_go_out(flash_go_out), .flash_row_addr_out(flash_row_addr_out), .core_stall_out(core_stall_out),
  .table_ea_in(table_ea_in), .table_addr_out(table_addr_out), .table_config_space_out(table_config_space_out));
`default_nettype wire

// ---- verif/fsp_flash_model.sv ----
// model of the flash array that obeys launch pulses
// assumes go is a one-cycle pulse with erase and row address valid
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // launch from the sequencer
  input wire logic go_in,
  input wire logic erase_in,
  input wire logic [23:0] row_in,
  // record of operations
  output logic [7:0] erase_cnt_out,
  output logic [7:0] prog_cnt_out,
  output logic [23:0] last_row_out
);
  // one whole 32-word row per launch, counted by kind
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      erase_cnt_out <= 8'h00;
      prog_cnt_out <= 8'h00;
      last_row_out <= 24'h00_0000;
    end
    else if (go_in)
    begin
      erase_cnt_out <= erase_cnt_out + {7'h00, erase_in};
      prog_cnt_out <= prog_cnt_out + {7'h00, !erase_in};
      last_row_out <= row_in;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_flash_row_self_programming.sv ----
// bench for the flash row sequencer with its flash model
// assumes a 100 MHz clock and a short operation count
`timescale 1ns/100ps
`default_nettype none
module tb_flash_row_self_programming;
  localparam int OPC = 20;
  logic mclk_in, nrst_in, avs_read_in, avs_write_in, flash_go_out, flash_erase_out, core_stall_out, cfg_sp, wreq;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, rdata, q;
  logic [15:0] ea;
  logic [23:0] row, taddr, last_row;
  logic [7:0] n_er, n_pr;
  int fails, cmp_count, n;
  fsp_sequencer #(.OP_CYCLES(OPC)) fsp_sequencer_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .flash_go_out(flash_go_out), .flash_erase_out(flash_erase_out),
    .flash_row_addr_out(row), .core_stall_out(core_stall_out), .table_ea_in(ea),
    .table_addr_out(taddr), .table_config_space_out(cfg_sp));
  fsp_flash_model fsp_flash_model_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .go_in(flash_go_out),
    .erase_in(flash_erase_out), .row_in(row), .erase_cnt_out(n_er), .prog_cnt_out(n_pr),
    .last_row_out(last_row));
  ////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus access, held until waitrequest is low
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    n = 0;
    // waitrequest is judged only at rising edges, where the access completes
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 1000);
    q = rdata;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 1000)
    begin
      fails++;
      report_and_stop();
    end
  endtask
  // unlock keys then control write
  task automatic start(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] c);
    bus(fsp_pkg::OFS_KEY, 1'b1, {24'h00_0000, k1});
    bus(fsp_pkg::OFS_KEY, 1'b1, {24'h00_0000, k2});
    bus(fsp_pkg::OFS_CONTROL, 1'b1, {16'h0000, c});
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    fails = 0;
    cmp_count = 0;
    nrst_in = 1'b0;
    avs_address_in = 5'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    ea = 16'hbeef;
    repeat (4) @(posedge mclk_in);
    nrst_in <= 1'b1;
    // reset values, key and unmapped read zero
    for (int i = 0; i < 6; i++)
    begin
      bus(5'(i * 4), 1'b0, 32'h0000_0000);
      chk("reg_rd", 32'h0000_0000, q);
    end
    bus(fsp_pkg::OFS_PAGE, 1'b1, 32'h0000_0012);
    bus(fsp_pkg::OFS_OFFSET, 1'b1, 32'h0000_3456);
    bus(fsp_pkg::OFS_PAGE, 1'b0, 32'h0000_0000);
    chk("page", 32'h0000_0012, q);
    bus(fsp_pkg::OFS_OFFSET, 1'b0, 32'h0000_0000);
    chk("offset", 32'h0000_3456, q);
    // broken sequences never launch
    start(8'haa, 8'h55, 16'hc041);
    start(8'h55, 8'haa, 16'h8041);
    bus(fsp_pkg::OFS_CONTROL, 1'b1, 32'h0000_c041);
    bus(fsp_pkg::OFS_KEY, 1'b1, 32'h0000_0055);
    start(8'h12, 8'haa, 16'hc041);
    chk("ops", 32'h0000_0000, {16'h0000, n_er, n_pr});
    bus(fsp_pkg::OFS_CONTROL, 1'b0, 32'h0000_0000);
    chk("ctrl_nostart", 32'h0000_4041, q);
    // row erase, read stalls until completion
    bus(fsp_pkg::OFS_CONTROL, 1'b1, 32'h0000_4041);
    start(8'h55, 8'haa, 16'hc041);
    @(negedge mclk_in);
    chk("go", 32'h0000_0001, {31'h0, flash_go_out});
    chk("stall_on", 32'h0000_0001, {31'h0, core_stall_out});
    repeat (2) @(posedge mclk_in);
    bus(fsp_pkg::OFS_CONTROL, 1'b0, 32'h0000_0000);
    chk("stall_wait", 32'h0000_0001, {31'h0, n > OPC - 4});
    chk("ctrl_done", 32'h0000_4041, q);
    chk("erase_cnt", 32'h0000_0001, {24'h00_0000, n_er});
    chk("row", 32'h0012_3440, {8'h00, last_row});
    // row program
    bus(fsp_pkg::OFS_CONTROL, 1'b1, 32'h0000_4001);
    start(8'h55, 8'haa, 16'hc001);
    bus(fsp_pkg::OFS_CONTROL, 1'b0, 32'h0000_0000);
    chk("ctrl_prog", 32'h0000_4001, q);
    chk("prog_cnt", 32'h0000_0001, {24'h00_0000, n_pr});
    // table address, configuration then user space
    bus(fsp_pkg::OFS_TBLPAGE, 1'b1, 32'h0000_0085);
    bus(fsp_pkg::OFS_TBLPAGE, 1'b0, 32'h0000_0000);
    chk("tbl", 32'h0185_beef, {7'h00, cfg_sp, taddr});
    ea <= 16'h1234;
    bus(fsp_pkg::OFS_TBLPAGE, 1'b1, 32'h0000_0005);
    bus(fsp_pkg::OFS_TBLPAGE, 1'b0, 32'h0000_0000);
    chk("tblpage", 32'h0000_0005, q);
    chk("tbl", 32'h0005_1234, {7'h00, cfg_sp, taddr});
    report_and_stop();
  end
endmodule
`default_nettype wire
